// ==== design/cmpe_pkg.sv ====
// Package and synchroniser/edge module for the comparator event block
// =====================================================================
// Shared constants and state types
// =====================================================================
package cmpe_pkg;
    // Register byte offsets (decoded on haddr[7:0])
    localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h04;
    // Field positions of comparator_status_control
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_REF_SEL    = 6;
    localparam int BIT_EVENT_FLAG = 5;
    localparam int BIT_IRQ_ENABLE = 4;
    localparam int BIT_LEVEL      = 3;
    localparam int BIT_PIN_ENABLE = 2;
    localparam int BIT_MODE_HI    = 1;
    localparam int BIT_MODE_LO    = 0;
    // Values after reset
    localparam logic [7:0]  STATUS_CONTROL_RST = 8'h00;
    localparam logic [7:0]  IRQ_MASK_RST       = 8'h20;
    localparam logic [31:0] RDATA_RST          = 32'h0000_0000;
    // Event mode encodings
    localparam logic [1:0] MODE_FALL_A  = 2'h0;
    localparam logic [1:0] MODE_RISE    = 2'h1;
    localparam logic [1:0] MODE_FALL_B  = 2'h2;
    localparam logic [1:0] MODE_TOGGLE  = 2'h3;
    // AHB transfer type for an active transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } cmpe_sync_s;

    // Main block state
    typedef struct packed {
        logic        en;
        logic        ref_sel;
        logic        flag;
        logic        irq_en;
        logic        pin_en;
        logic [1:0]  mode;
        logic        mask;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } cmpe_state_s;
endpackage : cmpe_pkg

// =====================================================================
// Two-stage synchroniser with edge detection
// =====================================================================
module cmpe_sync_edge (
    input  wire logic hclk,    // Bus clock
    input  wire logic hresetn, // Async reset, active low
    input  wire logic enable,  // Comparator enabled
    input  wire logic raw,     // Asynchronous comparator output
    output logic      level,   // Synchronised level
    output logic      rise,    // Rising edge pulse
    output logic      fall     // Falling edge pulse
);
    cmpe_pkg::cmpe_sync_s st;
    cmpe_pkg::cmpe_sync_s next_st;

    // First flop takes raw input; later stages clear while off
    always_comb begin
        next_st      = st;
        next_st.s1   = raw;
        next_st.s2   = enable & st.s1;
        next_st.prev = enable & st.s2;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign rise  = st.s2 & ~st.prev;
    assign fall  = ~st.s2 & st.prev;

    // Level follows input two edges later when enabled throughout
    sync_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (enable && $past(enable) && $past(enable, 2)) |-> level == $past(raw, 2))
        else $error("synchronised level does not follow input");
endmodule : cmpe_sync_edge

// ==== design/cmpe_comparator_event_control.sv ====
// Comparator event control block with AHB-Lite register access
// =====================================================================
module cmpe_comparator_event_control (
    input  wire logic        hclk,          // Bus clock, 20 MHz
    input  wire logic        hresetn,       // Async reset, active low
    input  wire logic        hsel,          // Slave select
    input  wire logic [31:0] haddr,         // Byte address
    input  wire logic [1:0]  htrans,        // Transfer type
    input  wire logic        hwrite,        // Write when high
    input  wire logic [2:0]  hsize,         // Transfer size
    input  wire logic [31:0] hwdata,        // Write data
    input  wire logic        hready,        // Bus ready
    output logic             hreadyout,     // Slave ready
    output logic             hresp,         // Response
    output logic [31:0]      hrdata,        // Read data
    input  wire logic        cmp_raw,       // Analog comparator output
    output logic             analog_enable, // Power up analog comparator
    output logic             reference_select, // Bandgap as non-inverting input
    output logic             comparator_out_pin,    // Level on pin
    output logic             comparator_out_pin_oe, // Pin driven
    output logic             irq,           // Interrupt request, level
    output logic             wake_req       // Wake from wait or stop
);
    // =================================================================
    // State and wires
    // =================================================================
    cmpe_pkg::cmpe_state_s st;
    cmpe_pkg::cmpe_state_s next_st;
    logic                  level;
    logic                  rise;
    logic                  fall;
    logic                  event_hit;
    logic                  addr_phase;
    logic                  clear_req;

    // Selected event from mode and edges
    function automatic logic event_of(input logic [1:0] mode,
                                      input logic       r,
                                      input logic       f);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            cmpe_pkg::MODE_FALL_A: hit = f;
            cmpe_pkg::MODE_RISE:   hit = r;
            cmpe_pkg::MODE_FALL_B: hit = f;
            cmpe_pkg::MODE_TOGGLE: hit = r | f;
        endcase
        return hit;
    endfunction : event_of

    // Register image as software sees it
    function automatic logic [31:0] read_of(input cmpe_pkg::cmpe_state_s s,
                                            input logic [7:0]            a,
                                            input logic                  lvl);
        logic [31:0] d;
        d = '0;
        if (a == cmpe_pkg::OFF_STATUS_CONTROL) begin
            d[cmpe_pkg::BIT_ENABLE]     = s.en;
            d[cmpe_pkg::BIT_REF_SEL]    = s.ref_sel;
            d[cmpe_pkg::BIT_EVENT_FLAG] = s.flag;
            d[cmpe_pkg::BIT_IRQ_ENABLE] = s.irq_en;
            d[cmpe_pkg::BIT_LEVEL]      = lvl;
            d[cmpe_pkg::BIT_PIN_ENABLE] = s.pin_en;
            d[cmpe_pkg::BIT_MODE_HI:cmpe_pkg::BIT_MODE_LO] = s.mode;
        end else if (a == cmpe_pkg::OFF_IRQ_MASK) begin
            d[cmpe_pkg::BIT_EVENT_FLAG] = s.mask;
        end
        return d;
    endfunction : read_of

    // =================================================================
    // Synchroniser and edge detector
    // =================================================================
    cmpe_sync_edge u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (st.en),
        .raw     (cmp_raw),
        .level   (level),
        .rise    (rise),
        .fall    (fall)
    );

    // Edge qualified by mode; none while disabled
    assign event_hit  = st.en & event_of(st.mode, rise, fall);
    assign addr_phase = hsel & hready & (htrans == cmpe_pkg::HTRANS_NONSEQ);
    assign clear_req  = st.wr_pend & (st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL)
                        & hwdata[cmpe_pkg::BIT_EVENT_FLAG];

    // =================================================================
    // Next state
    // =================================================================
    always_comb begin
        next_st = st;
        // Data phase of a write: store control fields
        if (st.wr_pend) begin
            if (st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL) begin
                next_st.en      = hwdata[cmpe_pkg::BIT_ENABLE];
                next_st.ref_sel = hwdata[cmpe_pkg::BIT_REF_SEL];
                next_st.irq_en  = hwdata[cmpe_pkg::BIT_IRQ_ENABLE];
                next_st.pin_en  = hwdata[cmpe_pkg::BIT_PIN_ENABLE];
                next_st.mode    = hwdata[cmpe_pkg::BIT_MODE_HI:cmpe_pkg::BIT_MODE_LO];
            end else if (st.wr_addr == cmpe_pkg::OFF_IRQ_MASK) begin
                next_st.mask    = hwdata[cmpe_pkg::BIT_EVENT_FLAG];
            end
        end
        // Write one clears; zero leaves the flag alone
        if (clear_req) begin
            next_st.flag = 1'b0;
        end
        // Event set wins over a clear in the same cycle
        if (event_hit) begin
            next_st.flag = 1'b1;
        end
        // Capture the address phase
        next_st.wr_pend = addr_phase & hwrite;
        next_st.wr_addr = haddr[7:0];
        // Read data sampled from the updated registers
        if (addr_phase && !hwrite) begin
            next_st.rdata = read_of(next_st, haddr[7:0], level);
        end
    end

    // Mask bit value after reset
    localparam logic IRQ_MASK_RST_BIT = cmpe_pkg::IRQ_MASK_RST[cmpe_pkg::BIT_EVENT_FLAG];

    // State register; reset also covers leaving stop through reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st         <= '0;
            st.mask    <= IRQ_MASK_RST_BIT;
            st.rdata   <= cmpe_pkg::RDATA_RST;
        end else begin
            st <= next_st;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = cmpe_pkg::HRESP_OKAY;
    assign hrdata    = st.rdata;

    // Analog control; comparison itself happens in the analog cell
    assign analog_enable    = st.en;
    assign reference_select = st.ref_sel;

    // Pin follows synchronised level only while enabled
    assign comparator_out_pin    = level & st.en & st.pin_en;
    assign comparator_out_pin_oe = st.en & st.pin_en;

    // Interrupt is a level; same signal wakes from wait and stop,
    // so the block runs unchanged in wait, stop and debug
    assign irq      = st.flag & st.irq_en & st.mask;
    assign wake_req = irq;

    // =================================================================
    // Checks
    // =================================================================
    flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        event_hit |=> st.flag)
        else $error("event did not set the flag");

    flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (clear_req && !event_hit) |=> !st.flag)
        else $error("write one did not clear the flag");

    flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.flag && !clear_req) |=> st.flag)
        else $error("flag lost without a clear");

    set_beats_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (clear_req && event_hit) |=> st.flag)
        else $error("clear beat a simultaneous event");

    irq_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.flag && st.irq_en && st.mask) |-> irq && wake_req)
        else $error("interrupt missing while flag set");

    irq_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.irq_en |-> !irq)
        else $error("interrupt while disabled");

    level_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.en |=> !level)
        else $error("level not zero while disabled");

    pin_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.en || !st.pin_en) |-> !comparator_out_pin_oe && !comparator_out_pin)
        else $error("pin driven while not enabled");

    pin_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        comparator_out_pin_oe |-> comparator_out_pin == level)
        else $error("pin does not show level");

    rise_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.en && st.mode == cmpe_pkg::MODE_RISE && fall && !st.flag && !rise)
        |=> !st.flag)
        else $error("falling edge set flag in rising mode");

    ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.wr_pend && st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL)
        |=> analog_enable == $past(hwdata[cmpe_pkg::BIT_ENABLE])
            && reference_select == $past(hwdata[cmpe_pkg::BIT_REF_SEL]))
        else $error("control write not applied");

    level_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[7:0] == cmpe_pkg::OFF_STATUS_CONTROL)
        |=> hrdata[cmpe_pkg::BIT_LEVEL] == $past(level))
        else $error("read level differs from synchronised level");

    // =================================================================
    // Register field checks
    // =================================================================
    // Mask bit takes the written value
    mask_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.wr_pend && st.wr_addr == cmpe_pkg::OFF_IRQ_MASK)
        |=> st.mask == $past(hwdata[cmpe_pkg::BIT_EVENT_FLAG]))
        else $error("mask write not applied");

    // Interrupt enable takes the written value
    irq_en_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.wr_pend && st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL)
        |=> st.irq_en == $past(hwdata[cmpe_pkg::BIT_IRQ_ENABLE]))
        else $error("interrupt enable write not applied");

    // Pin enable takes the written value
    pin_en_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.wr_pend && st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL)
        |=> st.pin_en == $past(hwdata[cmpe_pkg::BIT_PIN_ENABLE]))
        else $error("pin enable write not applied");

    // Mode field takes the written value
    mode_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.wr_pend && st.wr_addr == cmpe_pkg::OFF_STATUS_CONTROL)
        |=> st.mode == $past(hwdata[cmpe_pkg::BIT_MODE_HI:cmpe_pkg::BIT_MODE_LO]))
        else $error("mode write not applied");

    // Control fields hold without a write
    ctrl_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.wr_pend |=> $stable(st.en) && $stable(st.ref_sel) && $stable(st.irq_en)
            && $stable(st.pin_en) && $stable(st.mode))
        else $error("control field changed without a write");

    // Mask bit holds without a mask write
    mask_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(st.wr_pend && st.wr_addr == cmpe_pkg::OFF_IRQ_MASK) |=> $stable(st.mask))
        else $error("mask changed without a write");

    // =================================================================
    // Event and interrupt checks
    // =================================================================
    // Flag rises only through an event
    flag_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.flag && !event_hit) |=> !st.flag)
        else $error("flag set without an event");

    // No event while comparator is off
    off_no_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.en |-> !event_hit)
        else $error("event while comparator disabled");

    // Rising edge counts in rise and toggle modes
    rise_hit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.en && rise && (st.mode == cmpe_pkg::MODE_RISE || st.mode == cmpe_pkg::MODE_TOGGLE))
        |-> event_hit)
        else $error("rising edge missed");

    // Falling edge counts in all but rise mode
    fall_hit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.en && fall && st.mode != cmpe_pkg::MODE_RISE) |-> event_hit)
        else $error("falling edge missed");

    // Rising edge ignored in falling modes
    fall_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ((st.mode == cmpe_pkg::MODE_FALL_A || st.mode == cmpe_pkg::MODE_FALL_B) && rise)
        |-> !event_hit)
        else $error("rising edge counted in falling mode");

    // Every rise of the level is an edge
    level_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (level && !$past(level)) |-> rise)
        else $error("level rise without edge pulse");

    // Every fall of the level while on is an edge
    level_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!level && $past(level) && $past(st.en)) |-> fall)
        else $error("level fall without edge pulse");

    // No interrupt without the flag
    irq_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.flag |-> !irq)
        else $error("interrupt without flag");

    // No interrupt while masked
    irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.mask |-> !irq)
        else $error("interrupt while masked");

    // Pin driven while both enables set
    pin_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.en && st.pin_en) |-> comparator_out_pin_oe)
        else $error("pin not driven while enabled");

    // =================================================================
    // Read data checks
    // =================================================================
    // Read data holds between reads
    rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(addr_phase && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");

    // Upper read bits are zero
    read_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite) |=> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    // Set flag reads back as set
    read_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[7:0] == cmpe_pkg::OFF_STATUS_CONTROL
            && st.flag && !clear_req) |=> hrdata[cmpe_pkg::BIT_EVENT_FLAG])
        else $error("set flag reads as clear");

    // Flag set while interrupt masked
    masked_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        st.flag && !st.mask);

    toggle_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        st.en && st.mode == cmpe_pkg::MODE_TOGGLE && fall ##1 st.flag);

    race_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        clear_req && event_hit);

    wake_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(wake_req));

    pin_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        comparator_out_pin_oe && $rose(comparator_out_pin));
endmodule : cmpe_comparator_event_control

// ==== tb/cmpe_comparator_event_control_tb.sv ====
// Self-checking testbench for the comparator event control block
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp); end end

module cmpe_comparator_event_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // =================================================================
    // Signals and counters
    // =================================================================
    localparam logic [31:0] A_CTRL = {24'h0, cmpe_pkg::OFF_STATUS_CONTROL};
    localparam logic [31:0] A_MASK = {24'h0, cmpe_pkg::OFF_IRQ_MASK};
    logic        hclk, hresetn, hsel, hwrite, cmp_raw, mask_on;
    logic [31:0] haddr, hwdata, rd, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic   hready;
    logic        hreadyout, hresp, analog_enable, reference_select;
    logic        comparator_out_pin, comparator_out_pin_oe, irq, wake_req;
    logic [31:0] hrdata;
    int          num_errors, checked, cycles;

    assign hready = hreadyout; // Single slave on the bus

    cmpe_comparator_event_control dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_raw(cmp_raw),
        .analog_enable(analog_enable), .reference_select(reference_select),
        .comparator_out_pin(comparator_out_pin),
        .comparator_out_pin_oe(comparator_out_pin_oe), .irq(irq), .wake_req(wake_req));

    // Bus clock, 50 ns period
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Cycle limit against hangs
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    // =================================================================
    // Tasks and functions
    // =================================================================
    // Flag expected after an edge towards lvl in mode m
    function automatic logic exp_flag(input logic [1:0] m, input logic lvl);
        return lvl ? m[0] : (m != cmpe_pkg::MODE_RISE);
    endfunction : exp_flag

    // Verdict and end of run
    task automatic finish_test();
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                            output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= cmpe_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb_xfer

    // Values after any reset
    task automatic check_reset();
        ahb_xfer(1'b0, A_CTRL, 32'h0, rd);
        `CHK(rd, {24'h0, cmpe_pkg::STATUS_CONTROL_RST}, "ctrl reset")
        ahb_xfer(1'b0, A_MASK, 32'h0, rd);
        `CHK(rd, {24'h0, cmpe_pkg::IRQ_MASK_RST}, "mask reset")
        `CHK({irq, comparator_out_pin_oe, analog_enable}, 3'b000, "outputs reset")
        `CHK({hresp, hreadyout}, {cmpe_pkg::HRESP_OKAY, 1'b1}, "bus reset")
        `CHK({wake_req, comparator_out_pin, reference_select}, 3'b000, "pins reset")
    endtask : check_reset

    // Clear flag, make one edge towards lvl, check flag, level, pin and irq
    task automatic check_edge(input logic [1:0] m, input logic lvl, input logic pe,
                              input logic rs, input logic ie);
        logic [7:0] cfg;
        logic       f;
        cfg = {1'b1, rs, 1'b0, ie, 1'b0, pe, m};
        f   = exp_flag(m, lvl);
        cmp_raw <= ~lvl;
        repeat (4) @(posedge hclk);
        ahb_xfer(1'b1, A_CTRL, {24'h0, cfg | 8'h20}, rd);
        cmp_raw <= lvl;
        repeat (4) @(posedge hclk);
        ahb_xfer(1'b1, A_CTRL, {24'h0, cfg}, rd);
        ahb_xfer(1'b0, A_CTRL, 32'h0, rd);
        `CHK(rd, {24'h0, cfg | {2'b0, f, 1'b0, lvl, 3'b0}}, "ctrl")
        `CHK(irq, f & ie & mask_on, "irq")
        `CHK(wake_req, f & ie & mask_on, "wake")
        `CHK(comparator_out_pin, lvl & pe, "pin")
        `CHK(comparator_out_pin_oe, pe, "pin enable")
        `CHK({analog_enable, reference_select}, {1'b1, rs}, "analog")
        ahb_xfer(1'b1, A_CTRL, {24'h0, cfg | 8'h20}, rd);
        @(posedge hclk);
        `CHK(irq, 1'b0, "irq after clear")
    endtask : check_edge

    // =================================================================
    // Main sequence
    // =================================================================
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        cmp_raw = 1'b0;
        mask_on = 1'b1;
        r       = $urandom(32'h254c);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_reset();
        // Unmapped place ignores writes and reads zero
        ahb_xfer(1'b1, 32'h0000_0008, 32'h0000_00ff, rd);
        ahb_xfer(1'b0, 32'h0000_0008, 32'h0, rd);
        `CHK(rd, 32'h0, "unmapped")
        // Every mode and both edge directions
        for (int m = 0; m < 4; m++) begin
            check_edge(m[1:0], 1'b1, 1'b1, 1'b0, 1'b1);
            check_edge(m[1:0], 1'b0, 1'b1, 1'b1, 1'b1);
        end
        // Random configurations
        repeat (16) begin
            r = $urandom;
            check_edge(r[1:0], r[2], r[3], r[4], r[5]);
        end
        // Interrupt masked while flag still sets
        ahb_xfer(1'b1, A_MASK, 32'h0, rd);
        mask_on = 1'b0;
        check_edge(cmpe_pkg::MODE_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b1);
        ahb_xfer(1'b1, A_MASK, 32'h0000_0020, rd);
        mask_on = 1'b1;
        // Falling edge lands in the data phase of a clearing write
        cmp_raw <= 1'b0;
        @(posedge hclk);
        ahb_xfer(1'b1, A_CTRL, 32'h0000_00b3, rd);
        ahb_xfer(1'b0, A_CTRL, 32'h0, rd);
        `CHK(rd, 32'h0000_00b3, "set beats clear")
        // Disabled: level reads zero, pin released, no events
        cmp_raw <= 1'b1;
        ahb_xfer(1'b1, A_CTRL, 32'h0000_0027, rd);
        cmp_raw <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb_xfer(1'b0, A_CTRL, 32'h0, rd);
        `CHK(rd, 32'h0000_0007, "disabled")
        `CHK({comparator_out_pin, comparator_out_pin_oe, analog_enable}, 3'b000, "off")
        // Reset in mid-run restores reset state
        ahb_xfer(1'b1, A_CTRL, 32'h0000_00d7, rd);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_reset();
        finish_test();
    end
endmodule : cmpe_comparator_event_control_tb
